// ### logic/srac_defines.svh
// Constants of the SPI target command decoder
//
// What this block does
// R1: Register address steps by one per byte, 0xFFF wraps to 0x000.
// R2: Reset is command 0b0000, address 0x000, no data.
// R3: Reset acts only when chip select rises.
// R4: Reset restores power-on state and configuration mode; RAM kept.
// R5: Host sends reset only in configuration mode.
// R6: Read 0b0011: bytes from consecutive addresses until chip select rises.
// R7: Write 0b0010: each register byte commits after its eighth bit.
// R8: Pin configuration register takes single-byte writes only.
// R9: RAM moves in 4-byte words; address wraps 0xBFF to 0x400.
// R10: RAM accesses force the two low address bits to zero.
// R11: RAM read fetches a word after the address and every fourth byte.
// R12: Host reads RAM in whole words, dropping a partial one.
// R13: RAM write commits full words; a partial word is dropped.
// R14: CRC presets to all ones per frame, runs with the shifter.
// R15: CRC-16 polynomial 0x8005 over command, address, count and data.
// R16: On mismatch the computed CRC is stored and the mismatch flag set.
// R17: Checked read 0b1011: address, count, data, then CRC high byte first.
// R18: Checked read mismatches raise no flag.
// R19: Chip select rising before the CRC ends sets the short-frame flag.
// R20: Checked write 0b1010 with count; bytes commit before the CRC check.
// R21: Checked write compares received and computed CRC at the end.
// R22: Safe write 0b1100: one byte or word, committed only on matching CRC.
// R23: Frames open on chip select low; sample on rising, drive on falling SCK.
// R24: Undefined commands are ignored: SDO idle, nothing written.
`ifndef SRAC_DEFINES_SVH
`define SRAC_DEFINES_SVH

// Command codes
`define SRAC_CMD_RESET      4'h0
`define SRAC_CMD_WRITE      4'h2
`define SRAC_CMD_READ       4'h3
`define SRAC_CMD_WRITE_CRC  4'ha
`define SRAC_CMD_READ_CRC   4'hb
`define SRAC_CMD_WRITE_SAFE 4'hc
`define SRAC_CMD_NONE       4'hf

// Header fields
`define SRAC_HDR_CMD        15:12
`define SRAC_HDR_ADDR       11:0

// Address space
`define SRAC_RESET_ADDR     12'h000
`define SRAC_ADDR_STEP      12'h001
`define SRAC_RAM_BASE       12'h400
`define SRAC_RAM_TOP        12'hbff
`define SRAC_ALIGN_MASK     12'hffc

// CRC
`define SRAC_CRC_PRESET     16'hffff
`define SRAC_CRC_POLY       16'h8005
`define SRAC_CRC_ZERO       16'h0000

// Bit and byte counts
`define SRAC_CNT_ZERO       4'h0
`define SRAC_CNT_STEP       4'h1
`define SRAC_FIELD_LAST     4'hf
`define SRAC_BYTE_FIRST     3'h0
`define SRAC_BYTE_LAST      3'h7
`define SRAC_LANE_ZERO      2'h0
`define SRAC_WORD_LAST      2'h3
`define SRAC_N_ZERO         8'h00
`define SRAC_N_ONE          8'h01
`define SRAC_PAD24          24'h000000

// Synchroniser reset values
`define SRAC_SYNC_RST       4'h1

`endif

// ### logic/srac_pkg.sv
// Types shared by the SPI target command decoder
`default_nettype none

package srac_pkg;

    // Frame phases, Gray coded along header, count, data, CRC, done
    typedef enum logic [2:0]
    {
        PH_HDR  = 3'b000,
        PH_CNT  = 3'b001,
        PH_DATA = 3'b011,
        PH_CRC  = 3'b010,
        PH_DONE = 3'b110,
        PH_IGN  = 3'b111
    } srac_phase_t;

endpackage : srac_pkg

`default_nettype wire

// ### logic/srac_spi_target.sv
// SPI target command decoder
`include "srac_defines.svh"
`default_nettype none

module srac_spi_target
    import srac_pkg::*;
(
    // System side
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    // SPI link
    input  wire logic        SCK,
    input  wire logic        CS_B,
    input  wire logic        SDI,
    output var  logic        SDO,
    output var  logic        SDO_OE,
    // Register and message RAM access
    output var  logic        REG_WR,
    output var  logic        REG_RD,
    output var  logic        RAM_WR,
    output var  logic        RAM_RD,
    output var  logic [11:0] ACC_ADDR,
    output var  logic [31:0] ACC_WDATA,
    input  wire logic [7:0]  REG_RDATA,
    input  wire logic [31:0] RAM_RDATA,
    // CRC status
    input  wire logic        FLAG_CLEAR,
    output var  logic        CRC_MISMATCH_FLAG,
    output var  logic        CRC_FRAME_SHORT_FLAG,
    output var  logic [15:0] CRC_VALUE,
    // Device reset request
    output var  logic        SOFT_RESET
);

    // ------------------------------------------------------------
    // CRC step
    // ------------------------------------------------------------

    // One bit of MSB-first CRC, no reflection, no final inversion
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SRAC_CRC_POLY : `SRAC_CRC_ZERO);
    endfunction : crc_step

    // ------------------------------------------------------------
    // Link domain declarations
    // ------------------------------------------------------------

    logic        frame_live;
    srac_phase_t phase;
    logic [3:0]  bit_cnt;
    logic [15:0] sh;
    logic [3:0]  cmd;
    logic        in_ram;
    logic [11:0] addr;
    logic [11:0] addr0;
    logic [7:0]  n_left;
    logic [15:0] crc;
    logic [15:0] rx_crc;
    logic [31:0] word_buf;
    logic        crc_done;
    logic        reset_req;
    logic        load_now;
    logic        frame_tgl;
    logic        wr_tgl;
    logic        rd_tgl;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic        wr_ram;
    logic [11:0] rd_addr;
    logic        rd_ram;
    logic [6:0]  out_sh;

    // System domain declarations
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic        frame_seen;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // Link domain decode
    // ------------------------------------------------------------

    // Chip select or system reset idles the link at once
    wire         link_idle = CS_B | ~RST_B;

    // First edge of a frame starts from preset state
    srac_phase_t ph;
    assign ph = frame_live ? phase : PH_HDR;
    wire [3:0]   cnt     = frame_live ? bit_cnt : `SRAC_CNT_ZERO;
    wire [15:0]  crc_cur = frame_live ? crc : `SRAC_CRC_PRESET;  // see R14
    wire [15:0]  sh_n    = {sh[14:0], SDI};                     // see R23

    // Header fields as they complete
    wire [3:0]   h_cmd   = sh_n[`SRAC_HDR_CMD];
    wire [11:0]  h_addr  = sh_n[`SRAC_HDR_ADDR];
    wire         h_ram   = (h_addr >= `SRAC_RAM_BASE) && (h_addr <= `SRAC_RAM_TOP);
    wire [11:0]  addr_w  = h_ram ? (h_addr & `SRAC_ALIGN_MASK) : h_addr;  // see R10
    wire [3:0]   cmd_w   = (ph == PH_HDR) ? h_cmd : cmd;

    // Command classes
    wire         c_read  = cmd_w == `SRAC_CMD_READ;
    wire         c_rcrc  = cmd_w == `SRAC_CMD_READ_CRC;
    wire         c_wcrc  = cmd_w == `SRAC_CMD_WRITE_CRC;
    wire         c_safe  = cmd_w == `SRAC_CMD_WRITE_SAFE;
    wire         is_rd   = c_read | c_rcrc;
    wire         is_chk  = c_rcrc | c_wcrc;
    wire         is_wr   = (cmd_w == `SRAC_CMD_WRITE) | c_wcrc | c_safe;
    wire         rst_ok  = (h_cmd == `SRAC_CMD_RESET) && (h_addr == `SRAC_RESET_ADDR);  // see R2
    wire         known   = is_rd | is_wr;

    // Field boundaries
    wire         hdr_end  = (ph == PH_HDR) && (cnt == `SRAC_FIELD_LAST);
    wire         byte_end = cnt[2:0] == `SRAC_BYTE_LAST;
    wire         cnt_end  = (ph == PH_CNT) && byte_end;
    wire         dat_end  = (ph == PH_DATA) && byte_end;
    wire         crc_end  = (ph == PH_CRC) && (cnt == `SRAC_FIELD_LAST);
    wire         w_last   = addr[1:0] == `SRAC_WORD_LAST;

    // Address advance: RAM wraps to its base, registers wrap on 12 bits
    wire [11:0]  addr_inc = (in_ram && (addr == `SRAC_RAM_TOP)) ? `SRAC_RAM_BASE
                            : addr + `SRAC_ADDR_STEP;  // see R1, R9
    wire [1:0]   lane     = in_ram ? addr[1:0] : `SRAC_LANE_ZERO;

    // Data ends on count, or on one byte or word for safe writes
    wire         safe_full = in_ram ? w_last : 1'b1;                         // see R22
    wire         data_last = dat_end && (is_chk ? (n_left == `SRAC_N_ONE)   // see R17, R20
                                       : (c_safe & safe_full));

    // CRC input: read data comes from our own SDO bit
    wire         crc_bit = ((ph == PH_DATA) && is_rd) ? SDO : SDI;
    wire         crc_upd = (ph == PH_HDR) || (ph == PH_CNT) || (ph == PH_DATA);
    wire [15:0]  crc_n   = crc_upd ? crc_step(crc_cur, crc_bit) : crc_cur;  // see R15

    // Byte lanes of the word buffer and the read word
    logic [31:0] wb_n;
    logic [7:0]  rd_b [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign wb_n[8*g +: 8] = (lane == g) ? sh_n[7:0] : word_buf[8*g +: 8];
            assign rd_b[g]        = rd_word[8*g +: 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // Link domain next state
    // ------------------------------------------------------------

    srac_phase_t next_phase;

    // Phase sequencing; unknown commands park in the ignore phase
    always_comb
    begin
        next_phase = ph;
        case (ph)
            PH_HDR:
            begin
                if (hdr_end)
                    next_phase = rst_ok ? PH_DONE : !known ? PH_IGN  // see R24
                               : is_chk ? PH_CNT : PH_DATA;
            end
            PH_CNT:
            begin
                if (byte_end)
                    next_phase = (sh_n[7:0] == `SRAC_N_ZERO) ? PH_CRC : PH_DATA;
            end
            PH_DATA:
            begin
                if (data_last)
                    next_phase = PH_CRC;
            end
            PH_CRC:
            begin
                if (crc_end)
                    next_phase = PH_DONE;
            end
            PH_DONE: next_phase = PH_DONE;
            PH_IGN:  next_phase = PH_IGN;
            default: next_phase = PH_IGN;
        endcase
    end

    // Counter restarts on each new field
    wire [3:0]   next_cnt  = (next_phase != ph) ? `SRAC_CNT_ZERO : cnt + `SRAC_CNT_STEP;

    // A fresh output byte is due on the next falling edge
    wire         next_load = is_rd && (next_cnt[2:0] == `SRAC_BYTE_FIRST) &&
                             ((next_phase == PH_DATA) ||
                              ((next_phase == PH_CRC) && is_chk));  // see R17, R23

    wire [3:0]   next_cmd  = hdr_end ? h_cmd : (frame_live ? cmd : `SRAC_CMD_NONE);
    wire [11:0]  next_addr = hdr_end ? addr_w : (dat_end ? addr_inc : addr);
    wire [7:0]   next_n    = cnt_end ? sh_n[7:0] : (dat_end ? n_left - `SRAC_N_ONE : n_left);

    // Writes: registers per byte, RAM per full word, safe writes wait for the CRC
    wire         wr_go = is_wr && !c_safe && dat_end && (!in_ram || w_last);  // see R7, R13, R20

    // Reads: first fetch after the header or count, then prefetch ahead
    wire         rd_hdr  = hdr_end && c_read;                                  // see R6
    wire         rd_cnt  = cnt_end && c_rcrc;
    wire         rd_pre  = (ph == PH_DATA) && is_rd && !in_ram &&
                           (cnt[2:0] == `SRAC_BYTE_FIRST);
    wire         rd_nxtw = dat_end && is_rd && in_ram && w_last;               // see R11
    wire         rd_go   = rd_hdr | rd_cnt | rd_pre | rd_nxtw;
    wire [11:0]  rd_at   = rd_hdr ? addr_w : (rd_cnt ? addr : addr_inc);

    // ------------------------------------------------------------
    // Link domain registers
    // ------------------------------------------------------------

    // Frame presence, cleared the moment chip select rises
    always_ff @(posedge SCK or posedge link_idle)
    begin
        if (link_idle)
            frame_live <= 1'b0;
        else
            frame_live <= 1'b1;
    end

    // Frame state; values stay frozen after the frame for the system side
    always_ff @(posedge SCK)
    begin
        phase     <= next_phase;
        bit_cnt   <= next_cnt;
        sh        <= sh_n;
        load_now  <= next_load;
        cmd       <= next_cmd;
        in_ram    <= hdr_end ? h_ram : in_ram;
        addr      <= next_addr;
        addr0     <= hdr_end ? addr_w : addr0;
        n_left    <= next_n;
        crc       <= crc_n;                                          // see R14
        word_buf  <= dat_end ? wb_n : word_buf;
        rx_crc    <= (ph == PH_CRC) ? {rx_crc[14:0], SDI} : rx_crc;
        crc_done  <= crc_end | (frame_live & crc_done);              // see R19
        reset_req <= hdr_end ? rst_ok : (frame_live & reset_req);    // see R2
    end

    // Events toward the system side travel as toggles with held data
    always_ff @(posedge SCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            frame_tgl <= 1'b0;
            wr_tgl    <= 1'b0;
            rd_tgl    <= 1'b0;
            wr_addr   <= `SRAC_RESET_ADDR;
            wr_data   <= {`SRAC_PAD24, 8'h00};
            wr_ram    <= 1'b0;
            rd_addr   <= `SRAC_RESET_ADDR;
            rd_ram    <= 1'b0;
        end
        else
        begin
            frame_tgl <= frame_tgl ^ ~frame_live;
            wr_tgl    <= wr_tgl ^ wr_go;
            rd_tgl    <= rd_tgl ^ rd_go;
            if (wr_go)
            begin
                wr_addr <= in_ram ? (addr & `SRAC_ALIGN_MASK) : addr;  // see R10
                wr_data <= wb_n;
                wr_ram  <= in_ram;
            end
            if (rd_go)
            begin
                rd_addr <= rd_at;
                rd_ram  <= hdr_end ? h_ram : in_ram;
            end
        end
    end

    // Output byte: read data lane, or the CRC high then low byte
    wire [7:0]   out_byte = (phase == PH_CRC) ? (bit_cnt[3] ? crc[7:0] : crc[15:8])
                            : rd_b[in_ram ? addr[1:0] : `SRAC_LANE_ZERO];

    // SDO changes on falling SCK; enabled only once read data starts
    always_ff @(negedge SCK or posedge link_idle)
    begin
        if (link_idle)
        begin
            SDO    <= 1'b0;
            out_sh <= 7'h00;
            SDO_OE <= 1'b0;
        end
        else if (load_now)
        begin
            {SDO, out_sh} <= out_byte;                              // see R6, R17, R23
            SDO_OE        <= 1'b1;
        end
        else
        begin
            {SDO, out_sh} <= {out_sh, 1'b0};
        end
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------

    // Two-stage synchronisers plus a history stage for edges
    wire [3:0]   lnk = {frame_tgl, rd_tgl, wr_tgl, CS_B};

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            sync1 <= `SRAC_SYNC_RST;
            sync2 <= `SRAC_SYNC_RST;
            sync3 <= `SRAC_SYNC_RST;
        end
        else
        begin
            sync1 <= lnk;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Events; link data is stable long before its toggle lands here
    wire         wr_ev  = sync2[1] ^ sync3[1];
    wire         rd_ev  = sync2[2] ^ sync3[2];
    wire         end_ev = sync2[0] & ~sync3[0] & (sync2[3] ^ frame_seen);

    // End-of-frame judgement on the frozen link state
    wire         e_chk   = (cmd == `SRAC_CMD_READ_CRC) | (cmd == `SRAC_CMD_WRITE_CRC) |
                           (cmd == `SRAC_CMD_WRITE_SAFE);
    wire         e_wchk  = (cmd == `SRAC_CMD_WRITE_CRC) | (cmd == `SRAC_CMD_WRITE_SAFE);
    wire         crc_bad = crc != rx_crc;
    wire         form_set = end_ev & e_chk & ~crc_done;                      // see R19
    wire         mis_set  = end_ev & e_wchk & crc_done & crc_bad;            // see R18, R21
    wire         safe_ok  = end_ev & (cmd == `SRAC_CMD_WRITE_SAFE) & crc_done & ~crc_bad;
    wire         rst_ev   = end_ev & reset_req;                              // see R3

    // Access strobes; one access at most per system cycle
    wire         next_reg_wr = (wr_ev & ~wr_ram) | (safe_ok & ~in_ram);      // see R22
    wire         next_ram_wr = (wr_ev & wr_ram) | (safe_ok & in_ram);
    wire [11:0]  next_acc_a  = wr_ev ? wr_addr : safe_ok ? addr0 : rd_ev ? rd_addr : ACC_ADDR;
    wire [31:0]  next_acc_d  = wr_ev ? wr_data : safe_ok ? word_buf : ACC_WDATA;

    // Bus side registers; read data is taken at the edge closing the strobe
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            REG_WR    <= 1'b0;
            RAM_WR    <= 1'b0;
            REG_RD    <= 1'b0;
            RAM_RD    <= 1'b0;
            ACC_ADDR  <= `SRAC_RESET_ADDR;
            ACC_WDATA <= {`SRAC_PAD24, 8'h00};
            rd_word   <= {`SRAC_PAD24, 8'h00};
        end
        else
        begin
            REG_WR    <= next_reg_wr;
            RAM_WR    <= next_ram_wr;
            REG_RD    <= rd_ev & ~rd_ram;
            RAM_RD    <= rd_ev & rd_ram;
            ACC_ADDR  <= next_acc_a;
            ACC_WDATA <= next_acc_d;
            rd_word   <= RAM_RD ? RAM_RDATA : REG_RD ? {`SRAC_PAD24, REG_RDATA} : rd_word;
        end
    end

    // Status: a new event wins over a clear in the same cycle; reset clears all
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            frame_seen           <= 1'b0;
            CRC_MISMATCH_FLAG    <= 1'b0;
            CRC_FRAME_SHORT_FLAG <= 1'b0;
            CRC_VALUE            <= `SRAC_CRC_ZERO;
            SOFT_RESET           <= 1'b0;
        end
        else
        begin
            frame_seen           <= end_ev ? sync2[3] : frame_seen;
            SOFT_RESET           <= rst_ev;                                    // see R4
            CRC_MISMATCH_FLAG    <= ~rst_ev & (mis_set | (CRC_MISMATCH_FLAG & ~FLAG_CLEAR));
            CRC_FRAME_SHORT_FLAG <= ~rst_ev & (form_set |
                                    (CRC_FRAME_SHORT_FLAG & ~FLAG_CLEAR));
            CRC_VALUE            <= rst_ev ? `SRAC_CRC_ZERO : mis_set ? crc : CRC_VALUE;  // see R16
        end
    end

endmodule : srac_spi_target

`default_nettype wire

// ### verification/srac_spi_target_chk.sv
// Port checker of the SPI target command decoder
`default_nettype none

module srac_spi_target_chk
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    // Observed ports
    input  wire logic        CS_B,
    input  wire logic        SDO,
    input  wire logic        SDO_OE,
    input  wire logic        REG_WR,
    input  wire logic        RAM_WR,
    input  wire logic        RAM_RD,
    input  wire logic [11:0] ACC_ADDR,
    input  wire logic        FLAG_CLEAR,
    input  wire logic        CRC_MISMATCH_FLAG,
    input  wire logic        CRC_FRAME_SHORT_FLAG,
    input  wire logic [15:0] CRC_VALUE,
    input  wire logic        SOFT_RESET
);
    // System clock domain
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    // Reset only after the frame
    AST_SOFT_AFTER_CS: assert property (SOFT_RESET |-> CS_B)
        else $error("soft reset raised inside a frame");
    AST_SOFT_CLEARS: assert property (SOFT_RESET |=> !CRC_MISMATCH_FLAG
        && !CRC_FRAME_SHORT_FLAG && CRC_VALUE == 16'h0000)
        else $error("soft reset left status behind");
    // Aligned RAM words
    AST_RAM_WR_WORD: assert property (RAM_WR |-> ACC_ADDR[1:0] == 2'h0
        && ACC_ADDR >= 12'h400 && ACC_ADDR <= 12'hbff)
        else $error("bad RAM write address");
    AST_RAM_RD_WORD: assert property (RAM_RD |-> ACC_ADDR[1:0] == 2'h0)
        else $error("RAM read address not aligned");
    AST_REG_WR_SPACE: assert property (REG_WR |-> ACC_ADDR < 12'h400
        || ACC_ADDR > 12'hbff)
        else $error("byte write landed in RAM space");
    AST_WR_PULSE: assert property (REG_WR |=> !REG_WR && !RAM_WR)
        else $error("write strobe too long");
    // SDO idle outside frames and writes
    AST_IDLE_SDO: assert property (CS_B && $past(CS_B) |-> !SDO_OE && !SDO)
        else $error("SDO active outside a frame");
    AST_NO_OE_ON_WRITE: assert property (REG_WR || RAM_WR |-> !SDO_OE)
        else $error("SDO driven during a write");
    // Sticky flags, set after the frame
    AST_FLAG_STICKY: assert property ($fell(CRC_MISMATCH_FLAG)
        || $fell(CRC_FRAME_SHORT_FLAG) |-> $past(FLAG_CLEAR) || $past(SOFT_RESET) || SOFT_RESET)
        else $error("CRC flag dropped without a clear");
    AST_SET_AT_END: assert property ($rose(CRC_MISMATCH_FLAG)
        || $rose(CRC_FRAME_SHORT_FLAG) |-> CS_B)
        else $error("CRC flag set inside a frame");

    // Main scenarios reached
    COV_RAM_WR: cover property (RAM_WR);
    COV_MISMATCH: cover property ($rose(CRC_MISMATCH_FLAG));
    COV_SOFT: cover property (SOFT_RESET);
endmodule : srac_spi_target_chk

`default_nettype wire

// ### verification/srac_host_model.sv
// Host SPI master model, mode 0,0, collecting SDO bytes
`default_nettype none

module srac_host_model
(
    // SPI link
    output var  logic SCK,
    output var  logic CS_B,
    output var  logic SDI,
    input  wire logic SDO
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx[$];

    // Clock stands still low between frames
    initial
    begin
        SCK = 1'b0;
        CS_B = 1'b1;
        SDI = 1'b0;
    end

    // One frame; SCK is stretched at byte edges so read data can cross clocks
    task automatic frame(input logic [7:0] tx[$]);
        logic [7:0] b;
        rx.delete();
        CS_B = 1'b0;
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                SDI = tx[i][k];
                #(k == 7 ? 424 : 24);
                SCK = 1'b1;
                b[k] = SDO;
                #(k == 0 ? 424 : 24);
                SCK = 1'b0;
            end
            rx.push_back(b);
        end
        #24;
        CS_B = 1'b1;
        SDI = ~SDI; // Released line shows no stale value
        #200;
    endtask : frame
endmodule : srac_host_model

`default_nettype wire

// ### verification/srac_spi_target_tb.sv
// Bench of the SPI target command decoder
`default_nettype none

module srac_spi_target_tb;
    import srac_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        SYS_CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        FLAG_CLEAR = 1'b0;
    logic        SCK, CS_B, SDI, SDO, SDO_OE, REG_WR, REG_RD, RAM_WR, RAM_RD, SOFT_RESET;
    logic        CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG;
    logic [11:0] ACC_ADDR;
    logic [31:0] ACC_WDATA, RAM_RDATA;
    logic [15:0] CRC_VALUE;
    logic [7:0]  REG_RDATA;
    logic [44:0] wq[$];
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          soft_cnt = 0;

    always #20 SYS_CLK = ~SYS_CLK;

    srac_spi_target uut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCK(SCK), .CS_B(CS_B),
        .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .RAM_WR(RAM_WR), .RAM_RD(RAM_RD), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA),
        .REG_RDATA(REG_RDATA), .RAM_RDATA(RAM_RDATA), .FLAG_CLEAR(FLAG_CLEAR),
        .CRC_MISMATCH_FLAG(CRC_MISMATCH_FLAG), .CRC_FRAME_SHORT_FLAG(CRC_FRAME_SHORT_FLAG),
        .CRC_VALUE(CRC_VALUE), .SOFT_RESET(SOFT_RESET));
    srac_host_model host (.SCK(SCK), .CS_B(CS_B), .SDI(SDI), .SDO(SDO));

    // Read data is a function of the address
    function automatic logic [7:0] fb(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction : fb
    assign REG_RDATA = fb(ACC_ADDR);
    assign RAM_RDATA = {fb(ACC_ADDR + 12'h3), fb(ACC_ADDR + 12'h2),
                        fb(ACC_ADDR + 12'h1), fb(ACC_ADDR)};

    // Bitwise CRC, MSB first, no reflection
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = 16'hffff;
        foreach (q[i])
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][k]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction : crc16

    // Write log and hang guard
    always @(posedge SYS_CLK)
    begin
        cycles <= cycles + 1;
        if (REG_WR === 1'b1 || RAM_WR === 1'b1)
            wq.push_back({RAM_WR, ACC_ADDR, RAM_WR ? ACC_WDATA : {24'h000000, ACC_WDATA[7:0]}});
        if (SOFT_RESET === 1'b1)
            soft_cnt <= soft_cnt + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic check(input logic [44:0] got, input logic [44:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : check
    task automatic expw(input logic ram, input logic [11:0] a, input logic [31:0] d);
        check(wq.size() ? wq.pop_front() : 45'bx, {ram, a, d});
    endtask : expw
    task automatic run(input logic [7:0] q[$]);
        host.frame(q);
        repeat (4) @(negedge SYS_CLK);
    endtask : run
    // Appends the CRC, high byte first
    task automatic crc_run(input logic [7:0] q[$], input logic [15:0] flip);
        logic [15:0] c;
        c = crc16(q) ^ flip;
        q.push_back(c[15:8]);
        q.push_back(c[7:0]);
        run(q);
    endtask : crc_run
    task automatic clear_flags();
        FLAG_CLEAR = 1'b1;
        @(negedge SYS_CLK);
        FLAG_CLEAR = 1'b0;
        @(negedge SYS_CLK);
    endtask : clear_flags
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] q[$];
        repeat (2) @(negedge SYS_CLK);
        RST_B = 1'b1;
        repeat (3) @(negedge SYS_CLK);
        run('{8'h2f, 8'hff, 8'ha1, 8'hb2});
        expw(1'b0, 12'hfff, 32'ha1);
        expw(1'b0, 12'h000, 32'hb2);
        run('{8'h30, 8'hff, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 3; i++)
            check(host.rx[i + 2], fb(12'h0ff + i));
        // Unaligned RAM write across the top
        run('{8'h2b, 8'hfe, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18});
        expw(1'b1, 12'hbfc, 32'h13121110);
        expw(1'b1, 12'h400, 32'h17161514);
        check(wq.size(), 0);
        run('{8'h3b, 8'hfd, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 8; i++)
            check(host.rx[i + 2], fb(i < 4 ? 12'hbfc + i : 12'h3fc + i));
        // Checked write, good then corrupted CRC
        q = '{8'ha0, 8'h20, 8'h02, 8'h5c, 8'h3d};
        crc_run(q, 16'h0000);
        expw(1'b0, 12'h020, 32'h5c);
        expw(1'b0, 12'h021, 32'h3d);
        check({CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG}, 2'h0);
        crc_run(q, 16'h0001);
        expw(1'b0, 12'h020, 32'h5c);
        expw(1'b0, 12'h021, 32'h3d);
        check({CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG}, 2'h2);
        check(CRC_VALUE, crc16(q));
        clear_flags();
        // Checked read: data then CRC
        q = '{8'hb0, 8'h10, 8'h02, fb(12'h010), fb(12'h011)};
        run('{8'hb0, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00});
        check({host.rx[3], host.rx[4]}, {q[3], q[4]});
        check({host.rx[5], host.rx[6]}, crc16(q));
        check({CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG}, 2'h0);
        run('{8'hb0, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00});
        check({CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG}, 2'h1);
        clear_flags();
        // Safe write
        crc_run('{8'hc0, 8'h30, 8'h77}, 16'h0000);
        expw(1'b0, 12'h030, 32'h77);
        crc_run('{8'hc0, 8'h30, 8'h77}, 16'h8000);
        check({wq.size(), CRC_MISMATCH_FLAG}, 1);
        // Undefined command
        run('{8'h5f, 8'h00, 8'haa, 8'h55});
        check({wq.size(), host.rx[2], host.rx[3]}, 0);
        // Reset needs address zero
        run('{8'h00, 8'h01});
        check(soft_cnt, 0);
        run('{8'h00, 8'h00});
        check(soft_cnt, 1);
        check({CRC_MISMATCH_FLAG, CRC_FRAME_SHORT_FLAG, CRC_VALUE}, 0);
        conclude();
    end
endmodule : srac_spi_target_tb

bind srac_spi_target srac_spi_target_chk chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .CS_B(CS_B), .SDO(SDO), .SDO_OE(SDO_OE), .REG_WR(REG_WR), .RAM_WR(RAM_WR),
    .RAM_RD(RAM_RD), .ACC_ADDR(ACC_ADDR), .FLAG_CLEAR(FLAG_CLEAR),
    .CRC_MISMATCH_FLAG(CRC_MISMATCH_FLAG), .CRC_FRAME_SHORT_FLAG(CRC_FRAME_SHORT_FLAG),
    .CRC_VALUE(CRC_VALUE), .SOFT_RESET(SOFT_RESET));

`default_nettype wire
